// ==== rtl/timer_defs.svh ====
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define OFF_CLK_CFG   8'h00
`define OFF_CTL       8'h04
`define OFF_LIMIT     8'h08
`define OFF_VALUE     8'h0C
`define OFF_STATE     8'h10
`define OFF_CC0       8'h14
`define OFF_CC1       8'h18

`define CLK_SRC       2:0
`define CLK_DIV       6:3
`define CLK_DEBUG_RUN_ENABLE     8
`define CTL_EN        0
`define CTL_PRESET    1
`define CTL_RUN       2
`define CTL_DIR       5:4
`define CTL_ONESHOT   6
`define CTL_MAX_WRITE_BUSY    8
`define ST_RUNNING    0
`define ST_UP         1
`define CC_FIELDS     5:0

`define SRC_OPCLK     3'h0
`define SRC_EV0_RISE  3'h1
`define SRC_EV0_FALL  3'h2
`define SRC_EV1_RISE  3'h3
`define SRC_EV1_FALL  3'h4
`define DUMMY_EDGES   2'h2
`define CNT_ZERO      16'h0000
`define WORD_ZERO     32'h0000_0000

`endif

// ==== rtl/timer_pkg.sv ====
package timer_pkg;
  typedef enum logic [1:0] {dir_up, dir_down, dir_updown, dir_updown_alt} count_dir_t;
endpackage : timer_pkg

// ==== rtl/count_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"

module count_tick_gen (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [2:0] clk_src,
  input  wire logic [3:0] clk_div,
  input  wire logic       halt,
  input  wire logic [1:0] event_clock_pin,
  output var  logic       tick
);
  logic [1:0]  s1_ff, s2_ff, s3_ff, lvl_ff;
  logic [1:0]  rise, fall;
  logic [1:0]  dummy_ff;
  logic [14:0] pre_ff;
  logic [2:0]  src_q_ff;
  logic        ev_src, edge_hit, raw_ok;

  function automatic logic [14:0] div_mask(input logic [3:0] d);
    div_mask = 15'((16'h0001 << d) - 16'h0001);
  endfunction : div_mask

  // three-stage synchroniser; a level change counts once stages 2 and 3 agree
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff  <= 2'h0;
      s2_ff  <= 2'h0;
      s3_ff  <= 2'h0;
      lvl_ff <= 2'h0;
    end else begin
      s1_ff  <= event_clock_pin;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (lvl_ff & (s2_ff ^ s3_ff));
    end
  end

  assign rise = ~(s2_ff ^ s3_ff) & s2_ff & ~lvl_ff;
  assign fall = ~(s2_ff ^ s3_ff) & ~s2_ff & lvl_ff;
  assign ev_src = (clk_src != `SRC_OPCLK);

  always_comb begin
    case (clk_src)
      `SRC_OPCLK:    edge_hit = 1'b1;
      `SRC_EV0_RISE: edge_hit = rise[0];
      `SRC_EV0_FALL: edge_hit = fall[0];
      `SRC_EV1_RISE: edge_hit = rise[1];
      `SRC_EV1_FALL: edge_hit = fall[1];
      default:       edge_hit = 1'b0;
    endcase
  end

  // dummy edges are swallowed so the first count lands on the third event edge
  assign raw_ok = run && !halt && edge_hit && (!ev_src || dummy_ff == `DUMMY_EDGES);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dummy_ff <= 2'h0;
      src_q_ff <= 3'h0;
    end else begin
      src_q_ff <= clk_src;
      if (!run || clk_src != src_q_ff)
        dummy_ff <= 2'h0;
      else if (ev_src && !halt && edge_hit && dummy_ff != `DUMMY_EDGES)
        dummy_ff <= dummy_ff + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_ff <= 15'h0000;
      tick   <= 1'b0;
    end else begin
      tick <= raw_ok && (pre_ff == div_mask(clk_div));
      if (!run)
        pre_ff <= 15'h0000;
      else if (raw_ok)
        pre_ff <= (pre_ff == div_mask(clk_div)) ? 15'h0000 : pre_ff + 15'h0001;
    end
  end

  chk_halt_no_tick: assert property (@(posedge core_clk) disable iff (!rstn)
    halt |=> !tick) else $error("tick while channel halted");
  chk_dummy_edges: assert property (@(posedge core_clk) disable iff (!rstn)
    raw_ok && ev_src |-> dummy_ff == `DUMMY_EDGES) else $error("event tick before two dummies");
  cov_event_tick: cover property (@(posedge core_clk) disable iff (!rstn) raw_ok && ev_src);
endmodule : count_tick_gen
`default_nettype wire

// ==== rtl/timer_count_clock_core.sv ====
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"

module timer_count_clock_core (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic [1:0]  event_clock_pin,
  input  wire logic        sleep_mode,
  input  wire logic        source_sleep_stop,
  input  wire logic        debug_mode
);
  logic [2:0]              clock_source_sel_ff;
  logic [3:0]              clock_divide_sel_ff;
  logic                    debug_run_enable_ff;
  logic                    channel_enable_ff;
  timer_pkg::count_dir_t   count_direction_sel_ff;
  logic                    single_shot_sel_ff;
  logic                    preset_ff;
  logic                    counter_running_ff;
  logic                    count_up_ff;
  logic [15:0]             count_limit_ff;
  logic [15:0]             limit_shadow_ff;
  logic                    max_write_busy_ff;
  logic [15:0]             count_value_ff;
  logic [5:0]              cc_ctrl_ff [2];
  logic                    wr_pend_ff;
  logic [7:0]              wr_addr_ff;
  logic                    take;
  logic                    halt;
  logic                    tick;
  logic                    step;
  logic                    hw_stop;
  logic [15:0]             nxt_count;
  logic                    nxt_up;
  logic                    up_mode;
  logic                    down_mode;
  logic                    ctl_write;

  function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
    wr_hit = pend && (a == off);
  endfunction : wr_hit

  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = `WORD_ZERO;
    case (a)
      `OFF_CLK_CFG: begin
        read_word[`CLK_SRC]   = clock_source_sel_ff;
        read_word[`CLK_DIV]   = clock_divide_sel_ff;
        read_word[`CLK_DEBUG_RUN_ENABLE] = debug_run_enable_ff;
      end
      `OFF_CTL: begin
        read_word[`CTL_EN]      = channel_enable_ff;
        read_word[`CTL_RUN]     = counter_running_ff;
        read_word[`CTL_DIR]     = count_direction_sel_ff;
        read_word[`CTL_ONESHOT] = single_shot_sel_ff;
        read_word[`CTL_MAX_WRITE_BUSY]  = max_write_busy_ff;
      end
      `OFF_LIMIT: read_word[15:0] = limit_shadow_ff;
      `OFF_VALUE: read_word[15:0] = count_value_ff;
      `OFF_STATE: begin
        read_word[`ST_RUNNING] = counter_running_ff;
        read_word[`ST_UP]      = count_up_ff;
      end
      `OFF_CC0: read_word[`CC_FIELDS] = cc_ctrl_ff[0];
      `OFF_CC1: read_word[`CC_FIELDS] = cc_ctrl_ff[1];
      default:  read_word = `WORD_ZERO;
    endcase
  endfunction : read_word

  // zero-wait slave: every transfer is accepted and answered OKAY
  assign take = hsel && htrans[1] && hready;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata     <= `WORD_ZERO;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pend_ff <= take && hwrite;
      if (take)
        wr_addr_ff <= haddr[7:0];
      // read data sampled in the address phase so hrdata comes from a flop
      if (take && !hwrite)
        hrdata <= read_word(haddr[7:0]);
    end
  end

  // clock configuration
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clock_source_sel_ff <= `SRC_OPCLK;
      clock_divide_sel_ff <= 4'h0;
      debug_run_enable_ff <= 1'b0;
    end else if (wr_hit(wr_pend_ff, wr_addr_ff, `OFF_CLK_CFG)) begin
      clock_source_sel_ff <= hwdata[`CLK_SRC];
      clock_divide_sel_ff <= hwdata[`CLK_DIV];
      debug_run_enable_ff <= hwdata[`CLK_DEBUG_RUN_ENABLE];
    end
  end

  // compare/capture control: stored here and read back only; no logic here uses it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cc_ctrl_ff[0] <= 6'h00;
      cc_ctrl_ff[1] <= 6'h00;
    end else begin
      if (wr_hit(wr_pend_ff, wr_addr_ff, `OFF_CC0))
        cc_ctrl_ff[0] <= hwdata[`CC_FIELDS];
      if (wr_hit(wr_pend_ff, wr_addr_ff, `OFF_CC1))
        cc_ctrl_ff[1] <= hwdata[`CC_FIELDS];
    end
  end

  // mode control and preset pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      channel_enable_ff      <= 1'b0;
      count_direction_sel_ff <= timer_pkg::dir_up;
      single_shot_sel_ff     <= 1'b0;
      preset_ff              <= 1'b0;
    end else begin
      preset_ff <= 1'b0;
      if (wr_hit(wr_pend_ff, wr_addr_ff, `OFF_CTL)) begin
        channel_enable_ff      <= hwdata[`CTL_EN];
        count_direction_sel_ff <= timer_pkg::count_dir_t'(hwdata[`CTL_DIR]);
        single_shot_sel_ff     <= hwdata[`CTL_ONESHOT];
        preset_ff              <= hwdata[`CTL_PRESET];
      end
    end
  end

  // a software write in the same cycle as a one-shot end wins over the stop
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      counter_running_ff <= 1'b0;
    else if (wr_hit(wr_pend_ff, wr_addr_ff, `OFF_CTL))
      counter_running_ff <= hwdata[`CTL_RUN] && hwdata[`CTL_EN];
    else if (!channel_enable_ff || hw_stop)
      counter_running_ff <= 1'b0;
  end

  // the new maximum is taken one cycle after the write; busy covers that gap
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_limit_ff    <= `CNT_ZERO;
      limit_shadow_ff   <= `CNT_ZERO;
      max_write_busy_ff <= 1'b0;
    end else begin
      if (wr_hit(wr_pend_ff, wr_addr_ff, `OFF_LIMIT)) begin
        limit_shadow_ff   <= hwdata[15:0];
        max_write_busy_ff <= 1'b1;
      end else begin
        max_write_busy_ff <= 1'b0;
      end
      if (max_write_busy_ff)
        count_limit_ff <= limit_shadow_ff;
    end
  end

  assign halt = (sleep_mode && source_sleep_stop)
             || (debug_mode && !debug_run_enable_ff);

  count_tick_gen u_tick (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .run             (counter_running_ff),
    .clk_src         (clock_source_sel_ff),
    .clk_div         (clock_divide_sel_ff),
    .halt            (halt),
    .event_clock_pin (event_clock_pin),
    .tick            (tick)
  );

  assign step = counter_running_ff && tick;

  always_comb begin
    nxt_count = count_value_ff;
    hw_stop   = 1'b0;
    case (count_direction_sel_ff)
      timer_pkg::dir_up:   nxt_up = 1'b1;
      timer_pkg::dir_down: nxt_up = 1'b0;
      default:             nxt_up = count_up_ff;
    endcase
    if (preset_ff) begin
      if (count_direction_sel_ff == timer_pkg::dir_down)
        nxt_count = count_limit_ff;
      else
        nxt_count = `CNT_ZERO;
      nxt_up = (count_direction_sel_ff != timer_pkg::dir_down);
    end else if (step) begin
      case (count_direction_sel_ff)
        timer_pkg::dir_up: begin
          if (count_value_ff >= count_limit_ff) begin
            nxt_count = `CNT_ZERO;
            hw_stop   = single_shot_sel_ff;
          end else begin
            nxt_count = count_value_ff + 16'h0001;
          end
        end
        timer_pkg::dir_down: begin
          if (count_value_ff == `CNT_ZERO) begin
            nxt_count = count_limit_ff;
            hw_stop   = single_shot_sel_ff;
          end else begin
            nxt_count = count_value_ff - 16'h0001;
          end
        end
        default: begin
          if (count_up_ff) begin
            if (count_value_ff > count_limit_ff) begin
              nxt_count = `CNT_ZERO;
            end else if (count_value_ff == count_limit_ff) begin
              nxt_up = 1'b0;
              if (count_value_ff != `CNT_ZERO)
                nxt_count = count_value_ff - 16'h0001;
            end else begin
              nxt_count = count_value_ff + 16'h0001;
            end
          end else if (count_value_ff == `CNT_ZERO) begin
            hw_stop = single_shot_sel_ff;
            if (!single_shot_sel_ff) begin
              nxt_up    = 1'b1;
              nxt_count = count_value_ff + 16'h0001;
            end
          end else begin
            nxt_count = count_value_ff - 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_value_ff <= `CNT_ZERO;
      count_up_ff    <= 1'b1;
    end else begin
      count_value_ff <= nxt_count;
      count_up_ff    <= nxt_up;
    end
  end

  chk_preset_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    preset_ff && count_direction_sel_ff != timer_pkg::dir_down |=> count_value_ff == 16'h0000)
    else $error("preset did not clear counter");
  chk_preset_load: assert property (@(posedge core_clk) disable iff (!rstn)
    preset_ff && count_direction_sel_ff == timer_pkg::dir_down
      |=> count_value_ff == $past(count_limit_ff))
    else $error("preset did not load maximum");
  chk_up_wrap: assert property (@(posedge core_clk) disable iff (!rstn)
    !preset_ff && step && count_direction_sel_ff == timer_pkg::dir_up
      && count_value_ff >= count_limit_ff |=> count_value_ff == 16'h0000)
    else $error("up count did not wrap to zero");
  chk_oneshot_stop: assert property (@(posedge core_clk) disable iff (!rstn)
    hw_stop && !wr_hit(wr_pend_ff, wr_addr_ff, `OFF_CTL) |=> !counter_running_ff)
    else $error("one-shot did not stop");
  chk_hold_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    !step && !preset_ff |=> $stable(count_value_ff))
    else $error("counter moved without a count tick");
  chk_max_busy: assert property (@(posedge core_clk) disable iff (!rstn)
    max_write_busy_ff && !wr_hit(wr_pend_ff, wr_addr_ff, `OFF_LIMIT)
      |=> !max_write_busy_ff && count_limit_ff == $past(limit_shadow_ff))
    else $error("maximum not taken after busy");
  chk_down_status: assert property (@(posedge core_clk) disable iff (!rstn)
    count_direction_sel_ff == timer_pkg::dir_down ##1
      count_direction_sel_ff == timer_pkg::dir_down |-> !count_up_ff)
    else $error("direction status wrong in down mode");
  chk_bus_okay: assert property (@(posedge core_clk) disable iff (!rstn)
    take |=> hreadyout && !hresp) else $error("bus answer not OKAY");

  // shorthands for the count-path checks below
  assign up_mode   = (count_direction_sel_ff == timer_pkg::dir_up);
  assign down_mode = (count_direction_sel_ff == timer_pkg::dir_down);
  assign ctl_write = wr_hit(wr_pend_ff, wr_addr_ff, `OFF_CTL);

  chk_run_start: assert property (@(posedge core_clk) disable iff (!rstn)
    ctl_write && hwdata[`CTL_RUN] && hwdata[`CTL_EN] |=> counter_running_ff)
    else $error("run bit did not start counter");
  chk_enable_stop: assert property (@(posedge core_clk) disable iff (!rstn)
    !channel_enable_ff && !ctl_write |=> !counter_running_ff)
    else $error("counter runs while disabled");
  chk_repeat_keeps: assert property (@(posedge core_clk) disable iff (!rstn)
    step && up_mode && !single_shot_sel_ff && !ctl_write |=> counter_running_ff)
    else $error("repeat up count stopped itself");
  chk_up_status: assert property (@(posedge core_clk) disable iff (!rstn)
    up_mode |=> count_up_ff)
    else $error("direction status wrong in up mode");
  chk_state_read: assert property (@(posedge core_clk) disable iff (!rstn)
    take && !hwrite && haddr[7:0] == `OFF_STATE
      |=> hrdata[`ST_RUNNING] == $past(counter_running_ff)
        && hrdata[`ST_UP] == $past(count_up_ff))
    else $error("state register read wrong");
  chk_up_step: assert property (@(posedge core_clk) disable iff (!rstn)
    !preset_ff && step && up_mode && count_value_ff < count_limit_ff
      |=> count_value_ff == $past(count_value_ff) + 16'h0001)
    else $error("up count did not advance by one");
  chk_limit_bound: assert property (@(posedge core_clk) disable iff (!rstn)
    !preset_ff && step && up_mode |=> count_value_ff <= $past(count_limit_ff))
    else $error("up count passed the maximum");
  chk_down_step: assert property (@(posedge core_clk) disable iff (!rstn)
    !preset_ff && step && down_mode && count_value_ff != `CNT_ZERO
      |=> count_value_ff == $past(count_value_ff) - 16'h0001)
    else $error("down count did not step by one");
  chk_down_reload: assert property (@(posedge core_clk) disable iff (!rstn)
    !preset_ff && step && down_mode && count_value_ff == `CNT_ZERO
      |=> count_value_ff == $past(count_limit_ff))
    else $error("down count did not reload maximum");
  chk_updown_turn: assert property (@(posedge core_clk) disable iff (!rstn)
    !preset_ff && step && !up_mode && !down_mode && count_up_ff
      && count_value_ff == count_limit_ff |=> !count_up_ff)
    else $error("up/down count did not turn");
  chk_updown_lowered: assert property (@(posedge core_clk) disable iff (!rstn)
    !preset_ff && step && !up_mode && !down_mode && count_up_ff
      && count_value_ff > count_limit_ff |=> count_value_ff == `CNT_ZERO)
    else $error("up/down count not cleared");
  chk_halt_stops: assert property (@(posedge core_clk) disable iff (!rstn)
    halt |=> !step)
    else $error("count step while halted");

  cov_oneshot_end: cover property (@(posedge core_clk) disable iff (!rstn)
    hw_stop ##1 !counter_running_ff);
  cov_updown_turn: cover property (@(posedge core_clk) disable iff (!rstn)
    step && count_up_ff ##1 !count_up_ff && count_direction_sel_ff == timer_pkg::dir_updown);
  cov_limit_lowered: cover property (@(posedge core_clk) disable iff (!rstn)
    step && count_value_ff > count_limit_ff);
  cov_down_reload: cover property (@(posedge core_clk) disable iff (!rstn)
    step && down_mode && count_value_ff == `CNT_ZERO);
endmodule : timer_count_clock_core
`default_nettype wire

// ==== dv/tb_timer_count_clock_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"

module tb_timer_count_clock_core;
  logic        core_clk;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  event_clock_pin;
  logic        sleep_mode;
  logic        source_sleep_stop;
  logic        debug_mode;
  int          failures;
  int          checked;
  logic [31:0] a_v;
  logic [31:0] b_v;
  logic [31:0] st_v;
  int          p;
  logic [7:0]  offs [0:7] = '{`OFF_CLK_CFG, `OFF_CTL, `OFF_LIMIT, `OFF_VALUE,
                              `OFF_STATE, `OFF_CC0, `OFF_CC1, 8'h40};
  // rows: sleep, source stops in sleep, debug, debug-run, count held
  logic [4:0]  halt_tab [0:4] = '{5'b11001, 5'b10000, 5'b01000, 5'b00101, 5'b00110};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  timer_count_clock_core i_timer_count_clock_core (
    .core_clk          (core_clk),
    .rstn              (rstn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hready),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .event_clock_pin   (event_clock_pin),
    .sleep_mode        (sleep_mode),
    .source_sleep_stop (source_sleep_stop),
    .debug_mode        (debug_mode)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_in(input string what, input logic [31:0] lo, input logic [31:0] hi,
                        input logic [31:0] got);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("BAD %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : chk_in

  // address phase held until ready, then data phase held until ready
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    q = hrdata;
    if (hresp !== 1'b0) chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0, q);
  endtask : rd

  function automatic logic [31:0] ctl_word(input logic run, input logic pre,
                                           input timer_pkg::count_dir_t dir, input logic one);
    ctl_word = 32'h0;
    ctl_word[`CTL_EN] = 1'b1;
    ctl_word[`CTL_PRESET] = pre;
    ctl_word[`CTL_RUN] = run;
    ctl_word[`CTL_DIR] = dir;
    ctl_word[`CTL_ONESHOT] = one;
  endfunction : ctl_word

  task automatic setup(input logic [31:0] cfg, input logic [15:0] mx,
                       input timer_pkg::count_dir_t dir, input logic one);
    logic [31:0] v;
    wr(`OFF_CLK_CFG, cfg);
    wr(`OFF_CTL, ctl_word(1'b0, 1'b0, dir, one));
    wr(`OFF_LIMIT, {16'h0, mx});
    wr(`OFF_CTL, ctl_word(1'b0, 1'b1, dir, one));
    repeat (4) @(posedge core_clk);
    rd(`OFF_VALUE, v);
    chk("preset value", (dir == timer_pkg::dir_down) ? {16'h0, mx} : 32'h0, v);
    wr(`OFF_CTL, ctl_word(1'b1, 1'b0, dir, one));
  endtask : setup

  // rewrite the limit once the busy flag has dropped, or after 20 further polls
  task automatic set_limit(input logic [15:0] mx);
    logic [31:0] v;
    int          n;
    n = 0;
    rd(`OFF_CTL, v);
    while (v[`CTL_MAX_WRITE_BUSY] !== 1'b0 && n < 20) begin
      rd(`OFF_CTL, v);
      n++;
    end
    wr(`OFF_LIMIT, {16'h0, mx});
  endtask : set_limit

  task automatic pulse(input int pin, input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      event_clock_pin[pin] <= 1'b1;
      repeat (4) @(posedge core_clk);
      event_clock_pin[pin] <= 1'b0;
    end
  endtask : pulse

  initial begin
    failures = 0;
    checked = 0;
    repeat (40000) @(posedge core_clk);
    failures++;
    test_done();
  end

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    event_clock_pin = 2'b00;
    sleep_mode = 1'b0;
    source_sleep_stop = 1'b0;
    debug_mode = 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(offs[i], a_v);
      chk("reset value", (offs[i] == `OFF_STATE) ? 32'h2 : 32'h0, a_v);
    end
    wr(`OFF_CLK_CFG, 32'hFFFF_FFFF);
    rd(`OFF_CLK_CFG, a_v);
    chk("clock config", 32'h0000_017F, a_v);
    wr(`OFF_CC0, 32'hFFFF_FFD5);
    wr(`OFF_CC1, 32'h0000_002A);
    rd(`OFF_CC0, a_v);
    rd(`OFF_CC1, b_v);
    chk("capture ctrl 0", 32'h15, a_v);
    chk("capture ctrl 1", 32'h2A, b_v);
    wr(`OFF_LIMIT, 32'hABCD_1234);
    wr(`OFF_STATE, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(`OFF_LIMIT, a_v);
    chk("limit", 32'h1234, a_v);
    rd(`OFF_STATE, a_v);
    chk("state read only", 32'h2, a_v);
    rd(8'h40, a_v);
    chk("unmapped", 32'h0, a_v);
    for (int d = 0; d < 5; d++) begin
      setup({23'h0, 2'b00, d[3:0], `SRC_OPCLK}, 16'hFFFF, timer_pkg::dir_up, 1'b0);
      rd(`OFF_VALUE, a_v);
      repeat (800) @(posedge core_clk);
      rd(`OFF_VALUE, b_v);
      chk_in("count rate", (803 >> d) - 1, (803 >> d) + 1, b_v - a_v);
      rd(`OFF_STATE, st_v);
      chk("state up running", 32'h3, st_v);
    end
    setup({29'h0, `SRC_OPCLK}, 16'hFFFF, timer_pkg::dir_up, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(`OFF_CLK_CFG, {23'h0, halt_tab[i][1], 8'h00});
      sleep_mode <= halt_tab[i][4];
      source_sleep_stop <= halt_tab[i][3];
      debug_mode <= halt_tab[i][2];
      repeat (5) @(posedge core_clk);
      rd(`OFF_VALUE, a_v);
      repeat (50) @(posedge core_clk);
      rd(`OFF_VALUE, b_v);
      if (halt_tab[i][0]) chk("held count", a_v, b_v);
      else chk_in("count while not held", 32'd52, 32'd54, b_v - a_v);
      rd(`OFF_STATE, st_v);
      chk("state kept", 32'h3, st_v);
    end
    sleep_mode <= 1'b0;
    source_sleep_stop <= 1'b0;
    debug_mode <= 1'b0;
    for (int s = 1; s < 5; s++) begin
      p = (s - 1) / 2;
      setup({29'h0, s[2:0]}, 16'hFFFF, timer_pkg::dir_up, 1'b0);
      pulse(p, 2);
      pulse(1 - p, 2);
      pulse(p, 3);
      repeat (4) @(posedge core_clk);
      event_clock_pin[p] <= 1'b1;
      repeat (8) @(posedge core_clk);
      rd(`OFF_VALUE, a_v);
      chk("event count", 32'd3 + {31'h0, s[0]}, a_v);
      event_clock_pin[p] <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
    setup({29'h0, `SRC_OPCLK}, 16'd200, timer_pkg::dir_up, 1'b1);
    repeat (50) @(posedge core_clk);
    rd(`OFF_STATE, st_v);
    chk("one-shot running", 32'h3, st_v);
    repeat (300) @(posedge core_clk);
    rd(`OFF_STATE, st_v);
    chk("one-shot stopped", 32'h0, st_v & 32'h1);
    rd(`OFF_VALUE, a_v);
    chk("one-shot end value", 32'h0, a_v);
    rd(`OFF_CTL, a_v);
    chk("run bit after one-shot", 32'h0, a_v & 32'h4);
    setup({29'h0, `SRC_OPCLK}, 16'd9, timer_pkg::dir_up, 1'b0);
    for (int i = 0; i < 12; i++) begin
      repeat (i) @(posedge core_clk);
      rd(`OFF_VALUE, a_v);
      chk_in("wrapped count", 32'd0, 32'd9, a_v);
    end
    setup({29'h0, `SRC_OPCLK}, 16'hFFFF, timer_pkg::dir_up, 1'b0);
    repeat (300) @(posedge core_clk);
    set_limit(16'd10);
    repeat (5) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rd(`OFF_VALUE, a_v);
      chk_in("count after lowered limit", 32'd0, 32'd10, a_v);
    end
    set_limit(16'h8000);
    repeat (100) @(posedge core_clk);
    rd(`OFF_VALUE, a_v);
    chk_in("count after raised limit", 32'd11, 32'h8000, a_v);
    setup({29'h0, `SRC_OPCLK}, 16'hFFFF, timer_pkg::dir_down, 1'b0);
    rd(`OFF_STATE, st_v);
    chk("state down running", 32'h1, st_v);
    rd(`OFF_VALUE, a_v);
    rd(`OFF_VALUE, b_v);
    chk_in("down count", a_v - 4, a_v - 2, b_v);
    setup({29'h0, `SRC_OPCLK}, 16'h0005, timer_pkg::dir_down, 1'b1);
    repeat (2) @(posedge core_clk);
    rd(`OFF_VALUE, a_v);
    repeat (20) @(posedge core_clk);
    rd(`OFF_VALUE, b_v);
    rd(`OFF_STATE, st_v);
    chk_in("down one-shot mid", 32'h1, 32'h4, a_v);
    chk("down one-shot end", 32'h5, b_v);
    chk("down one-shot stopped", 32'h0, st_v);
    setup({29'h0, `SRC_OPCLK}, 16'h0005, timer_pkg::dir_updown_alt, 1'b1);
    repeat (7) @(posedge core_clk);
    rd(`OFF_STATE, st_v);
    rd(`OFF_VALUE, a_v);
    repeat (20) @(posedge core_clk);
    rd(`OFF_STATE, b_v);
    chk("up-down turned", 32'h1, st_v);
    chk_in("up-down falling", 32'h0, 32'h4, a_v);
    chk("up-down one-shot end", 32'h0, b_v & 32'h1);
    setup({29'h0, `SRC_OPCLK}, 16'hFFFF, timer_pkg::dir_updown, 1'b0);
    rd(`OFF_STATE, st_v);
    chk("state up-down start", 32'h3, st_v);
    wr(`OFF_CTL, ctl_word(1'b0, 1'b0, timer_pkg::dir_updown, 1'b0));
    rd(`OFF_VALUE, a_v);
    repeat (20) @(posedge core_clk);
    rd(`OFF_VALUE, b_v);
    chk("stopped count", a_v, b_v);
    rd(`OFF_STATE, st_v);
    chk("idle state", 32'h0, st_v & 32'h1);
    test_done();
  end
endmodule : tb_timer_count_clock_core
`default_nettype wire
